// *** hdl/eic_pkg.sv ***
// Purpose: constants, types and register map of the edge interrupt controller
// Assumes: one clock mclk at 25 MHz, synchronous active-low reset
// Notes: registers sit on aligned 32-bit words of an axi4-lite slave
//
// Behaviour
// - wakeup pin in wakeup mode sets its flag on the selected edge
// - wakeup edge bit 0 means falling edge, 1 rising; zero after reset
// - wakeup flags stay set when the core accepts the interrupt
// - writing 0 clears a wakeup flag, writing 1 does nothing
// - reset clears wakeup edge select and all eight wakeup flags
// - thirteen external sources: five request pins, eight wakeup pins
// - wakeup enable bit at 0 blocks all eight wakeup requests
// - all wakeup sources share vector 9; software reads flags
// - each request pin senses rising or falling edge per its edge bit
// - request pin in interrupt mode sets flag on edge; enable 0 blocks it
// - request pins 4..0 use vectors 8..4, pin 0 highest priority
// - twenty-three peripheral requests, two flag registers, vectors 20..11
// - peripheral request counts only while its enable bit is 1
// - highest fixed priority request is chosen, others stay pending
// - request is accepted only while global mask bit is 0
// - after current instruction, core pushes program counter and flags
// - exception start sets the global mask bit to 1
// - vector for accepted source is produced and handler is started
// - clearing write colliding with request: exception follows the write
// - latency 15 to 27 states: 1-13 wait, 4 save, 2, 4, 4
// - mode bit 0 to 1 while wakeup pin low sets a flag
// - flag clear right after a port mode write does not clear

package eic_pkg;

   // ---------------------------------------------------------------
   // bus and register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_WAKE_FLAGS = 8'h00;
   localparam logic [7:0] OFS_WAKE_EDGE = 8'h04;
   localparam logic [7:0] OFS_REQ_ONE = 8'h08;
   localparam logic [7:0] OFS_REQ_TWO = 8'h0C;
   localparam logic [7:0] OFS_EN_ONE = 8'h10;
   localparam logic [7:0] OFS_EN_TWO = 8'h14;
   localparam logic [7:0] OFS_REQ_EDGE = 8'h18;
   localparam logic [7:0] OFS_PORT_MODE = 8'h1C;
   localparam logic [7:0] OFS_COND = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int N_WAKE = 8;
   localparam int N_IRQ = 5;
   localparam int N_PER = 23;
   localparam int N_PER_LO = 8;
   localparam int N_SRC = 29;
   localparam int POS_WAKE_EN = 13;
   localparam int POS_IRQ_MODE = 8;
   localparam logic [7:0] WAKE_RST = 8'h00;
   localparam logic MASK_RST = 1'b1;

   // ---------------------------------------------------------------
   // vectors and sequence lengths in states
   // ---------------------------------------------------------------
   localparam logic [4:0] VEC_IRQ0 = 5'h04;
   localparam logic [4:0] VEC_WAKE = 5'h09;
   localparam logic [4:0] VEC_PER0 = 5'h0B;
   localparam logic [4:0] VEC_PER_SPAN = 5'h09;
   localparam logic [3:0] SAVE_LEN = 4'h4;
   localparam logic [3:0] VECT_LEN = 4'h2;
   localparam logic [3:0] FETCH_LEN = 4'h4;
   localparam logic [3:0] INTP_LEN = 4'h4;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_SAVE, ST_VECT, ST_FETCH, ST_INTP
   } eic_state_t;

   typedef struct packed {
      logic exc_active;
      logic stack_save;
      logic vect_fetch;
      logic handler_go;
      logic mask;
      logic [4:0] vector;
   } eic_core_t;

endpackage

// *** hdl/eic_top.sv ***
// Purpose: edge interrupt controller with axi4-lite register slave
// Assumes: pins synchronous to mclk; core pulses insn_done per instruction
// Notes: exception sequence timing is counted in mclk states

`timescale 1ns/100ps

module eic_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic [eic_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [eic_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt sources
   input wire logic [eic_pkg::N_WAKE-1:0] wakeup_pin,
   input wire logic [eic_pkg::N_IRQ-1:0] irq_pin,
   input wire logic [eic_pkg::N_PER-1:0] periph_event,
   // core exception sequencer
   input wire logic insn_done,
   output eic_pkg::eic_core_t core_out
);

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   // expand byte strobes to a bit mask
   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // merge write data into an old word under strobes
   function automatic logic [31:0] wr_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      return (old & ~byte_mask(strb)) | (data & byte_mask(strb));
   endfunction

   // vector of a source index, index 0 highest priority
   function automatic logic [4:0] src_vector(input logic [4:0] idx);
      logic [9:0] prod;
      prod = 10'h000;
      if (idx < 5'h05) begin
         return eic_pkg::VEC_IRQ0 + idx;
      end else if (idx == 5'h05) begin
         return eic_pkg::VEC_WAKE;
      end
      prod = (10'(idx) - 10'h006) * 10'(eic_pkg::VEC_PER_SPAN) / 10'h016;
      return eic_pkg::VEC_PER0 + prod[4:0];
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0] wake_flags_reg, wake_edge_reg, wake_mode_reg, wake_samp_reg;
   logic [4:0] irq_flags_reg, irq_en_reg, irq_edge_reg, irq_mode_reg;
   logic [4:0] irq_samp_reg;
   logic [22:0] per_flags_reg, per_en_reg;
   logic wake_en_reg, mask_reg, pmr_last_reg;
   logic [3:0] cnt_reg, cnt_next;
   logic [4:0] vec_reg;
   eic_pkg::eic_state_t st_reg, st_next;
   eic_pkg::eic_core_t core_reg;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
   wire wr_en = awready_reg;
   wire [7:0] wa = s_axi_awaddr;
   wire [31:0] wd = s_axi_wdata;
   wire [31:0] bm = byte_mask(s_axi_wstrb);
   wire [31:0] clr_word = ~wd & bm;
   wire wr_wflag = wr_en & (wa == eic_pkg::OFS_WAKE_FLAGS);
   wire wr_wedge = wr_en & (wa == eic_pkg::OFS_WAKE_EDGE);
   wire wr_req1 = wr_en & (wa == eic_pkg::OFS_REQ_ONE);
   wire wr_req2 = wr_en & (wa == eic_pkg::OFS_REQ_TWO);
   wire wr_en1 = wr_en & (wa == eic_pkg::OFS_EN_ONE);
   wire wr_en2 = wr_en & (wa == eic_pkg::OFS_EN_TWO);
   wire wr_redge = wr_en & (wa == eic_pkg::OFS_REQ_EDGE);
   wire wr_pmode = wr_en & (wa == eic_pkg::OFS_PORT_MODE);
   wire wr_cond = wr_en & (wa == eic_pkg::OFS_COND);
   wire wr_known = wr_wflag | wr_wedge | wr_req1 | wr_req2 | wr_en1 |
      wr_en2 | wr_redge | wr_pmode | wr_cond;
   wire rd_fire = s_axi_arvalid & ~arready_reg & ~rvalid_reg;

   // register views
   wire [31:0] req1_word = {19'h0, per_flags_reg[7:0], irq_flags_reg};
   wire [31:0] req2_word = {17'h0, per_flags_reg[22:8]};
   wire [31:0] en1_word = {18'h0, wake_en_reg, per_en_reg[7:0], irq_en_reg};
   wire [31:0] en2_word = {17'h0, per_en_reg[22:8]};
   wire [31:0] pmode_word = {19'h0, irq_mode_reg, wake_mode_reg};
   wire [31:0] stat_word = {24'h0, st_reg != eic_pkg::ST_IDLE, 2'h0,
      vec_reg};
   // register words merged with write data under strobes
   wire [31:0] wedge_m = wr_merge({24'h0, wake_edge_reg}, wd, s_axi_wstrb);
   wire [31:0] pmode_m = wr_merge(pmode_word, wd, s_axi_wstrb);
   wire [31:0] redge_m = wr_merge({27'h0, irq_edge_reg}, wd, s_axi_wstrb);
   wire [31:0] en1_m = wr_merge(en1_word, wd, s_axi_wstrb);
   wire [31:0] en2_m = wr_merge(en2_word, wd, s_axi_wstrb);
   wire [31:0] cond_m = wr_merge({31'h0, mask_reg}, wd, s_axi_wstrb);

   // read selection
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         eic_pkg::OFS_WAKE_FLAGS: rd_word = {24'h0, wake_flags_reg};
         eic_pkg::OFS_WAKE_EDGE: rd_word = {24'h0, wake_edge_reg};
         eic_pkg::OFS_REQ_ONE: rd_word = req1_word;
         eic_pkg::OFS_REQ_TWO: rd_word = req2_word;
         eic_pkg::OFS_EN_ONE: rd_word = en1_word;
         eic_pkg::OFS_EN_TWO: rd_word = en2_word;
         eic_pkg::OFS_REQ_EDGE: rd_word = {27'h0, irq_edge_reg};
         eic_pkg::OFS_PORT_MODE: rd_word = pmode_word;
         eic_pkg::OFS_COND: rd_word = {31'h0, mask_reg};
         eic_pkg::OFS_STATUS: rd_word = stat_word;
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // edge detection on gated pins
   // ---------------------------------------------------------------
   // a pin out of its mode reads high, so mode on while low is a fall
   wire [7:0] wake_gate = wake_mode_reg & wakeup_pin | ~wake_mode_reg;
   wire [7:0] wake_fall = wake_samp_reg & ~wake_gate;
   wire [7:0] wake_rise = ~wake_samp_reg & wake_gate & wake_mode_reg;
   wire [7:0] wake_spur = {8{wr_pmode}} & pmode_m[7:0] & ~wake_mode_reg &
      ~wakeup_pin; // mode on while low, any edge bit
   wire [7:0] wake_set = wake_edge_reg & wake_rise |
      ~wake_edge_reg & wake_fall | wake_spur;
   wire [4:0] irq_gate = irq_mode_reg & irq_pin | ~irq_mode_reg;
   wire [4:0] irq_fall = irq_samp_reg & ~irq_gate;
   wire [4:0] irq_rise = ~irq_samp_reg & irq_gate;
   wire [4:0] irq_set = irq_edge_reg & irq_rise |
      ~irq_edge_reg & irq_fall;
   wire [22:0] per_set = periph_event & per_en_reg;

   // ---------------------------------------------------------------
   // flag update, set wins over clear
   // ---------------------------------------------------------------
   wire clr_ok = ~pmr_last_reg;
   wire [7:0] wake_clr = (wr_wflag & clr_ok) ? clr_word[7:0] : 8'h00;
   wire [4:0] irq_clr = (wr_req1 & clr_ok) ? clr_word[4:0] : 5'h00;
   wire [22:0] per_clr = {(wr_req2 & clr_ok) ? clr_word[14:0] : 15'h0,
      (wr_req1 & clr_ok) ? clr_word[12:5] : 8'h00};
   // no term from acceptance: flags stay set when taken
   wire [7:0] wake_flags_next = wake_flags_reg & ~wake_clr | wake_set;
   wire [4:0] irq_flags_next = irq_flags_reg & ~irq_clr | irq_set;
   wire [22:0] per_flags_next = per_flags_reg & ~per_clr | per_set;

   // ---------------------------------------------------------------
   // priority selection
   // ---------------------------------------------------------------
   wire wake_pend = |wake_flags_reg & wake_en_reg;
   wire [28:0] pend = {per_flags_reg & per_en_reg, wake_pend,
      irq_flags_reg & irq_en_reg};
   logic [4:0] win_idx;
   always_comb begin
      win_idx = 5'h00;
      for (int i = eic_pkg::N_SRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win_idx = 5'(i);
         end
      end
   end
   wire [4:0] win_vec = src_vector(win_idx);
   // no accept during a register write: it completes first
   wire accept = (|pend) & ~mask_reg & ~wr_en;

   // ---------------------------------------------------------------
   // exception sequencer
   // ---------------------------------------------------------------
   wire last_save = cnt_reg == eic_pkg::SAVE_LEN - 4'h1;
   wire last_vect = cnt_reg == eic_pkg::VECT_LEN - 4'h1;
   wire last_fetch = cnt_reg == eic_pkg::FETCH_LEN - 4'h1;
   wire last_intp = cnt_reg == eic_pkg::INTP_LEN - 4'h1;
   wire begin_exc = (st_reg == eic_pkg::ST_WAIT) & insn_done;

   // next state of the sequence
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg + 4'h1;
      unique case (st_reg)
         eic_pkg::ST_IDLE: begin
            if (accept) begin
               st_next = eic_pkg::ST_WAIT;
            end
         end
         eic_pkg::ST_WAIT: begin
            cnt_next = 4'h0;
            if (insn_done) begin
               st_next = eic_pkg::ST_SAVE;
            end
         end
         eic_pkg::ST_SAVE: begin
            if (last_save) begin
               st_next = eic_pkg::ST_VECT;
               cnt_next = 4'h0;
            end
         end
         eic_pkg::ST_VECT: begin
            if (last_vect) begin
               st_next = eic_pkg::ST_FETCH;
               cnt_next = 4'h0;
            end
         end
         eic_pkg::ST_FETCH: begin
            if (last_fetch) begin
               st_next = eic_pkg::ST_INTP;
               cnt_next = 4'h0;
            end
         end
         eic_pkg::ST_INTP: begin
            if (last_intp) begin
               st_next = eic_pkg::ST_IDLE;
               cnt_next = 4'h0;
            end
         end
      endcase
   end

   // core outputs for the coming cycle
   wire mask_next = begin_exc | (wr_cond ? cond_m[0] : mask_reg);
   wire [4:0] vec_next = (st_reg == eic_pkg::ST_IDLE && accept) ?
      win_vec : vec_reg;
   wire eic_pkg::eic_core_t core_next;
   assign core_next.exc_active = st_next != eic_pkg::ST_IDLE;
   assign core_next.stack_save = st_next == eic_pkg::ST_SAVE;
   assign core_next.vect_fetch = st_next == eic_pkg::ST_VECT;
   assign core_next.handler_go = (st_reg == eic_pkg::ST_INTP) &
      last_intp;
   assign core_next.mask = mask_next;
   assign core_next.vector = vec_next;

   // ---------------------------------------------------------------
   // bus handshake registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         awready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= eic_pkg::RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= eic_pkg::RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else begin
         awready_reg <= wr_fire;
         bvalid_reg <= wr_en | bvalid_reg & ~s_axi_bready;
         bresp_reg <= wr_en ? (wr_known ? eic_pkg::RESP_OKAY :
            eic_pkg::RESP_SLVERR) : bresp_reg;
         arready_reg <= rd_fire;
         rvalid_reg <= arready_reg | rvalid_reg & ~s_axi_rready;
         rresp_reg <= arready_reg ? (rd_hit ? eic_pkg::RESP_OKAY :
            eic_pkg::RESP_SLVERR) : rresp_reg;
         rdata_reg <= arready_reg ? rd_word : rdata_reg;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wake_edge_reg <= eic_pkg::WAKE_RST;
         wake_mode_reg <= 8'h00;
         irq_mode_reg <= 5'h00;
         irq_edge_reg <= 5'h00;
         irq_en_reg <= 5'h00;
         per_en_reg <= 23'h000000;
         wake_en_reg <= 1'b0;
         pmr_last_reg <= 1'b0;
      end else begin
         wake_edge_reg <= wr_wedge ? wedge_m[7:0] : wake_edge_reg;
         wake_mode_reg <= wr_pmode ? pmode_m[7:0] : wake_mode_reg;
         irq_mode_reg <= wr_pmode ? pmode_m[12:8] : irq_mode_reg;
         irq_edge_reg <= wr_redge ? redge_m[4:0] : irq_edge_reg;
         irq_en_reg <= wr_en1 ? en1_m[4:0] : irq_en_reg;
         wake_en_reg <= wr_en1 ? en1_m[eic_pkg::POS_WAKE_EN] :
            wake_en_reg;
         per_en_reg <= {wr_en2 ? en2_m[14:0] : per_en_reg[22:8],
            wr_en1 ? en1_m[12:5] : per_en_reg[7:0]};
         pmr_last_reg <= wr_en ? wr_pmode : pmr_last_reg;
      end
   end

   // ---------------------------------------------------------------
   // flags, samples and sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wake_flags_reg <= eic_pkg::WAKE_RST;
         irq_flags_reg <= 5'h00;
         per_flags_reg <= 23'h000000;
         wake_samp_reg <= 8'hFF;
         irq_samp_reg <= 5'h1F;
         st_reg <= eic_pkg::ST_IDLE;
         cnt_reg <= 4'h0;
         vec_reg <= 5'h00;
         mask_reg <= eic_pkg::MASK_RST;
         core_reg <= '{default: 1'b0, mask: eic_pkg::MASK_RST};
      end else begin
         wake_flags_reg <= wake_flags_next;
         irq_flags_reg <= irq_flags_next;
         per_flags_reg <= per_flags_next;
         wake_samp_reg <= wake_gate;
         irq_samp_reg <= irq_gate;
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         vec_reg <= vec_next;
         mask_reg <= mask_next;
         core_reg <= core_next;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = awready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign core_out = core_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_wake_flag_set: assert property (wake_set != 8'h00 |=>
      (wake_flags_reg & $past(wake_set)) == $past(wake_set))
      else $error("wakeup edge did not set its flag");
   a_flags_no_autoclr: assert property (!wr_en |=>
      (wake_flags_reg & $past(wake_flags_reg)) == $past(wake_flags_reg))
      else $error("wakeup flag fell without a write");
   a_write_one_keeps: assert property (wr_wflag && wake_set == 8'h00
      |=> (wake_flags_reg & ~$past(wake_flags_reg)) == 8'h00)
      else $error("write set a wakeup flag");
   a_irq0_top_prio: assert property (st_reg == eic_pkg::ST_IDLE &&
      accept && irq_flags_reg[0] && irq_en_reg[0] |=>
      vec_reg == eic_pkg::VEC_IRQ0)
      else $error("pin 0 request not given vector 4");
   a_mask_holds_off: assert property (st_reg == eic_pkg::ST_IDLE &&
      mask_reg |=> st_reg == eic_pkg::ST_IDLE)
      else $error("request accepted while masked");
   a_mask_on_start: assert property (begin_exc |=> (mask_reg &&
      core_reg.mask) [*4])
      else $error("mask not set at exception start");
   a_write_first: assert property (st_reg == eic_pkg::ST_IDLE &&
      wr_en |=> st_reg == eic_pkg::ST_IDLE)
      else $error("exception accepted during a register write");
   a_seq_latency: assert property (begin_exc |-> ##15
      core_reg.handler_go && core_reg.vector == $past(vec_reg, 15))
      else $error("handler start not 15 states after instruction end");
   a_clr_after_mode: assert property (wr_wflag && pmr_last_reg |=>
      (wake_flags_reg & $past(wake_flags_reg)) == $past(wake_flags_reg))
      else $error("flag cleared right after a port mode write");

   c_wake_accept: cover property (st_reg == eic_pkg::ST_IDLE && accept &&
      win_vec == eic_pkg::VEC_WAKE);
   c_handler_go: cover property (core_reg.handler_go);
   c_set_and_clear: cover property (wr_wflag && (wake_set & wake_clr) != 0);
   c_spurious_mode: cover property (wr_pmode ##1 wake_fall != 8'h00);

endmodule

// *** sim/eic_core_model.sv ***
// Purpose: core side model ending the current instruction
// Assumes: one insn_done pulse per acceptance
// Notes: DLY sets the instruction wait, 1 to 13

`timescale 1ns/100ps

module eic_core_model #(parameter int DLY = 3) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // controller side
   input wire eic_pkg::eic_core_t core_out,
   output logic insn_done
);
   logic [3:0] cnt_reg;

   // pulse insn_done DLY+1 cycles after core_out.exc_active rises
   always_ff @(posedge mclk) begin
      if (!rst_n || !core_out.exc_active) begin
         cnt_reg <= 4'h0;
         insn_done <= 1'h0;
      end else begin
         cnt_reg <= (cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1;
         insn_done <= (cnt_reg == DLY[3:0]);
      end
   end
endmodule

// *** sim/tb.sv ***
// Purpose: register and sequence tests of the interrupt controller
// Assumes: axi4-lite master with bready and rready held high
// Notes: one peripheral pulse; a second reset closes the run

`timescale 1ns/100ps

module tb;
   logic mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic s_axi_bready, s_axi_rready, insn_done;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, wakeup_pin;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [4:0] irq_pin;
   logic [22:0] periph_event;
   eic_pkg::eic_core_t core_out;
   int miscompares, tests_run, n, m;

   eic_top uut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .wakeup_pin, .irq_pin, .periph_event,
      .insn_done, .core_out);
   eic_core_model #(.DLY(3)) core (.mclk, .rst_n, .core_out, .insn_done);

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic close_out;
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // one clock with a bounded wait budget
   task automatic tick;
      @(posedge mclk);
      n++;
      if (n > 60) begin
         miscompares++;
         $display("unexpected at %0t: timeout", $time);
         close_out;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      n = 0;
      // release each channel at the edge that takes it
      do begin
         tick;
         if (s_axi_awready === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1)
            s_axi_wvalid <= 1'h0;
      end while (s_axi_awvalid && s_axi_awready !== 1'h1 ||
         s_axi_wvalid && s_axi_wready !== 1'h1);
      do tick; while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      n = 0;
      do tick; while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do tick; while (s_axi_rvalid !== 1'h1);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
   endtask

   // wait for acceptance and handler start
   task automatic take(input logic [4:0] v);
      n = 0;
      do tick; while (core_out.exc_active !== 1'h1);
      chk({27'h0, core_out.vector}, {27'h0, v});
      n = 0;
      do tick; while (core_out.stack_save !== 1'h1);
      m = n;
      do tick; while (core_out.handler_go !== 1'h1);
      chk((n >= 15 && n <= 27) ? 32'h1 : 32'h0, 32'h1);
      chk(n - m, 32'hE);
      chk({31'h0, core_out.mask}, 32'h1);
   endtask

   initial begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end

   // ----------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------
   initial begin
      {miscompares, tests_run, n} = '0;
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awprot, s_axi_arprot, periph_event} = '0;
      s_axi_wstrb = 4'hF;
      wakeup_pin = 8'hFF;
      irq_pin = 5'h1F;
      repeat (20) @(posedge mclk);
      rst_n <= 1'h1;
      rd(8'h00);
      chk(rd_data, 32'h0);
      rd(8'h04);
      chk(rd_data, 32'h0);
      rd(8'h30);
      chk({30'h0, resp}, {30'h0, eic_pkg::RESP_SLVERR});
      wr(8'h1C, 32'h1FFF);
      wr(8'h04, 32'h0F);
      rd(8'h04);
      chk(rd_data, 32'h0F);
      wakeup_pin <= 8'h00;
      repeat (3) @(posedge mclk);
      rd(8'h00);
      chk(rd_data, 32'hF0);
      wakeup_pin <= 8'hFF;
      repeat (3) @(posedge mclk);
      rd(8'h00);
      chk(rd_data, 32'hFF);
      wr(8'h00, 32'hF0);
      rd(8'h00);
      chk(rd_data, 32'hF0);
      wr(8'h20, 32'h0);
      repeat (30) @(posedge mclk);
      chk({31'h0, core_out.mask}, 32'h0);
      wr(8'h10, 32'h2000);
      take(eic_pkg::VEC_WAKE);
      rd(8'h00);
      chk(rd_data, 32'hF0);
      rd(8'h24);
      chk(rd_data, {27'h0, eic_pkg::VEC_WAKE});
      wr(8'h18, 32'h04);
      irq_pin <= 5'h18;
      repeat (3) @(posedge mclk);
      rd(8'h08);
      chk(rd_data, 32'h03);
      irq_pin <= 5'h1F;
      repeat (3) @(posedge mclk);
      rd(8'h08);
      chk(rd_data, 32'h07);
      wr(8'h10, 32'h2003);
      wr(8'h20, 32'h0);
      take(eic_pkg::VEC_IRQ0);
      wr(8'h08, 32'hFFFFFFFE);
      rd(8'h08);
      chk(rd_data, 32'h06);
      wr(8'h20, 32'h0);
      take(eic_pkg::VEC_IRQ0 + 5'h1);
      wr(8'h1C, 32'h1FFF);
      wr(8'h00, 32'h0);
      rd(8'h00);
      chk(rd_data, 32'hF0);
      wr(8'h00, 32'h0);
      rd(8'h00);
      chk(rd_data, 32'h0);
      wr(8'h30, 32'h0);
      chk({30'h0, resp}, {30'h0, eic_pkg::RESP_SLVERR});
      wr(8'h1C, 32'h1F00);
      chk({30'h0, resp}, {30'h0, eic_pkg::RESP_OKAY});
      wakeup_pin <= 8'hEE;
      wr(8'h1C, 32'h1F11);
      rd(8'h00);
      chk(rd_data, 32'h11);
      wr(8'h14, 32'h1);
      periph_event <= 23'h000300;
      @(posedge mclk);
      periph_event <= 23'h000000;
      rd(8'h0C);
      chk(rd_data, 32'h1);
      rst_n <= 1'h0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'h1;
      rd(8'h00);
      chk(rd_data, 32'h0);
      rd(8'h04);
      chk(rd_data, 32'h0);
      close_out;
   end
endmodule
